// File: pkg/adcp_defs.vh
// Shared constants for the converter parallel output port
`ifndef ADCP_DEFS_VH
`define ADCP_DEFS_VH

// ========================================
// Data word
`define ADCP_DATA_W 16
`define ADCP_CODE_MAX 16'h7fff
`define ADCP_CODE_MIN 16'h8000
`define ADCP_RAW_W 18

// ========================================
// Timing (sample period in clocks, strobe low time)
`define ADCP_DECIM 8
`define ADCP_STROBE_HIGH 4
`define ADCP_CNT_W 4

// ========================================
// AXI4-Lite register map (byte addresses)
`define ADCP_REG_CTRL 4'h0
`define ADCP_REG_DATA 4'h4
`define ADCP_REG_INT_STATUS 4'h8
`define ADCP_REG_INT_MASK 4'hc
`define ADCP_AXI_ADDR_W 4
`define ADCP_RESP_OKAY 2'b00
`define ADCP_RESP_SLVERR 2'b10

// Control and status fields
`define ADCP_CTRL_EXTREF 0
`define ADCP_INT_READY 0
`define ADCP_INT_RANGE 1
`define ADCP_INT_W 2

`endif

// File: src/adcp_sync2.v
// Two flip-flop synchroniser for a single level
`timescale 1ns/10ps
module adcp_sync2 #(
    parameter [0:0] RST_VAL = 1'b0
) (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire d_i,
    output wire q_o
);
    reg meta_reg;
    reg sync_reg;

    // ========================================
    // Two stage capture, reset to the pin's idle level so no false edge follows reset
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end
    assign q_o = sync_reg;
endmodule // adcp_sync2

// File: src/adcp_clip.v
// Saturation of a wide signed result to a 16-bit two's complement word
`timescale 1ns/10ps
`include "adcp_defs.vh"
module adcp_clip #(
    parameter RAW_W = `ADCP_RAW_W
) (
    input wire [RAW_W-1:0] raw_i,
    output reg [`ADCP_DATA_W-1:0] code_o,
    output reg over_o
);
    localparam [RAW_W-1:0] MAXV = {{(RAW_W-`ADCP_DATA_W){1'b0}}, `ADCP_CODE_MAX};
    localparam [RAW_W-1:0] MINV = {{(RAW_W-`ADCP_DATA_W){1'b1}}, `ADCP_CODE_MIN};

    // ========================================
    // Clip beyond full scale; exactly full scale is not out of range
    always @* begin
        if (!raw_i[RAW_W-1] && (raw_i > MAXV)) begin
            code_o = `ADCP_CODE_MAX; // R8
            over_o = 1'b1;
        end else if (raw_i[RAW_W-1] && (raw_i < MINV)) begin
            code_o = `ADCP_CODE_MIN; // R9
            over_o = 1'b1;
        end else begin
            code_o = raw_i[`ADCP_DATA_W-1:0]; // R7 R12
            over_o = 1'b0;
        end
    end
endmodule // adcp_clip

// File: src/adcp_port.v
// Converter digital output port: reset, clipping, range flag, strobe, parallel bus, AXI4-Lite
// Operation
// R1: Low reset input clears the device at once, without a clock edge.
// R2: During reset all state clears, data bus low, ready strobe high.
// R3: Host should release reset on a falling sampling clock edge.
// R4: Ready strobe falls on the second rising edge after reset release.
// R5: Host waits 47 ready periods for filter settling before using data.
// R6: Shared clock and common reset make several converters strobe together.
// R7: Each result is a 16-bit two's complement word.
// R8: Above positive full scale the word clips to 7fff and flags.
// R9: Below negative full scale the word clips to 8000 and flags.
// R10: Flag stays set while the input stays beyond full scale.
// R11: Flag changes only at a falling edge of the ready strobe.
// R12: Exactly full scale gives 7fff or 8000 with the flag low.
// R13: A falling ready strobe announces each new word.
// R14: Bus is driven only while select and read are both low; the code drives it from the synchronised pins, three clocks late.
// R15: Reference select low enables the internal reference generators; the code keeps them off while the control bit is set.
// R16: Reference select high disables all three internal reference generators.
// R17: Sampling clock is supplied continuously from outside.
// R18: Host reads once per ready period, between two falling strobes.
`timescale 1ns/10ps
`include "adcp_defs.vh"
module adcp_port #(
    parameter DECIM = `ADCP_DECIM,
    parameter RAW_W = `ADCP_RAW_W
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire rst_n_i,
    input wire [RAW_W-1:0] filter_raw_i,
    input wire chip_select_n_i,
    input wire read_n_i,
    input wire external_ref_select_i,
    output reg [`ADCP_DATA_W-1:0] data_out_o,
    output reg data_oe_o,
    output reg sample_ready_n_o,
    output reg out_of_range_flag_o,
    output reg ref_positive_en_o,
    output reg ref_negative_en_o,
    output reg ref_mid_en_o,
    output reg irq_o,
    input wire [`ADCP_AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`ADCP_AXI_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    // Period end and strobe rise points, cut to the counter width on purpose
    localparam integer LAST_I = DECIM - 1;
    localparam integer HIGH_I = `ADCP_STROBE_HIGH - 1;
    localparam [`ADCP_CNT_W-1:0] LAST = LAST_I[`ADCP_CNT_W-1:0];
    localparam [`ADCP_CNT_W-1:0] HIGH_END = HIGH_I[`ADCP_CNT_W-1:0];
    localparam ST_RESET = 2'd0;
    localparam ST_FIRST = 2'd1;
    localparam ST_RUN = 2'd2;

    wire cs_n_sync;
    wire rd_n_sync;
    wire extref_sync;
    wire [`ADCP_DATA_W-1:0] clip_code;
    wire clip_over;
    reg [1:0] state_reg;
    reg [`ADCP_CNT_W-1:0] phase_reg;
    reg [`ADCP_DATA_W-1:0] word_reg;
    reg extref_ctrl_reg;
    reg [`ADCP_INT_W-1:0] int_status_reg;
    reg [`ADCP_INT_W-1:0] int_mask_reg;
    reg [`ADCP_INT_W-1:0] int_set;
    reg [`ADCP_INT_W-1:0] int_clr;
    reg [`ADCP_AXI_ADDR_W-1:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg aw_have_reg;
    reg w_have_reg;
    wire strobe_fall;
    wire ext_ref;

    // ========================================
    // Synchronise the host pins; select and read reset high so the bus stays off
    adcp_sync2 #(.RST_VAL(1'b1)) u_sync_cs (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(chip_select_n_i),
        .q_o(cs_n_sync)
    );
    adcp_sync2 #(.RST_VAL(1'b1)) u_sync_rd (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(read_n_i),
        .q_o(rd_n_sync)
    );
    adcp_sync2 u_sync_ref (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(external_ref_select_i),
        .q_o(extref_sync)
    );

    // ========================================
    // Clipping of the filter result
    adcp_clip #(.RAW_W(RAW_W)) u_clip (
        .raw_i(filter_raw_i),
        .code_o(clip_code),
        .over_o(clip_over)
    );

    // New word lands when the strobe falls, at the end of each period
    assign strobe_fall = ((state_reg == ST_FIRST) || (state_reg == ST_RUN && phase_reg == LAST));
    // Pin or control bit asks for the external reference
    assign ext_ref = extref_sync | extref_ctrl_reg;

    // ========================================
    // Sample timing, strobe, word capture and range flag
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin // R1
            state_reg <= ST_RESET; // R2
            phase_reg <= {`ADCP_CNT_W{1'b0}};
            word_reg <= {`ADCP_DATA_W{1'b0}};
            sample_ready_n_o <= 1'b1; // R2
            out_of_range_flag_o <= 1'b0;
            data_out_o <= {`ADCP_DATA_W{1'b0}}; // R2
            data_oe_o <= 1'b0;
        end else if (rst_i) begin
            state_reg <= ST_RESET;
            phase_reg <= {`ADCP_CNT_W{1'b0}};
            word_reg <= {`ADCP_DATA_W{1'b0}};
            sample_ready_n_o <= 1'b1;
            out_of_range_flag_o <= 1'b0;
            data_out_o <= {`ADCP_DATA_W{1'b0}};
            data_oe_o <= 1'b0;
        end else begin
            case (state_reg)
                ST_RESET: begin
                    state_reg <= ST_FIRST; // R4 first edge after release
                end
                ST_FIRST: begin
                    state_reg <= ST_RUN; // R4 strobe low on second edge
                    phase_reg <= {`ADCP_CNT_W{1'b0}};
                end
                ST_RUN: begin
                    if (phase_reg == LAST) begin
                        phase_reg <= {`ADCP_CNT_W{1'b0}};
                    end else begin
                        phase_reg <= phase_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_RESET;
                end
            endcase
            // Strobe falls with each new word, rises mid period
            if (strobe_fall) begin
                sample_ready_n_o <= 1'b0; // R4 R6 R13
                word_reg <= clip_code; // R7
                out_of_range_flag_o <= clip_over; // R10 R11 R12
            end else if (state_reg == ST_RUN && phase_reg == HIGH_END) begin
                sample_ready_n_o <= 1'b1;
            end
            // Parallel bus drive gated by select and read
            data_oe_o <= ~cs_n_sync & ~rd_n_sync; // R14
            data_out_o <= (~cs_n_sync & ~rd_n_sync) ? (strobe_fall ? clip_code : word_reg) :
                          {`ADCP_DATA_W{1'b0}};
        end
    end

    // ========================================
    // Reference generator enables
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_positive_en_o <= 1'b0;
            ref_negative_en_o <= 1'b0;
            ref_mid_en_o <= 1'b0;
        end else if (rst_i) begin
            ref_positive_en_o <= 1'b0; // R2
            ref_negative_en_o <= 1'b0;
            ref_mid_en_o <= 1'b0;
        end else begin
            ref_positive_en_o <= ~ext_ref; // R15 R16
            ref_negative_en_o <= ~ext_ref; // R15 R16
            ref_mid_en_o <= ~ext_ref; // R15 R16
        end
    end

    // ========================================
    // Interrupt events and clear by writing one
    always @* begin
        int_set = {`ADCP_INT_W{1'b0}};
        int_set[`ADCP_INT_READY] = strobe_fall;
        int_set[`ADCP_INT_RANGE] = strobe_fall & clip_over;
        int_clr = {`ADCP_INT_W{1'b0}};
        if (aw_have_reg && w_have_reg && !s_axi_bvalid && awaddr_reg == `ADCP_REG_INT_STATUS) begin
            int_clr = wdata_reg[`ADCP_INT_W-1:0];
        end
    end

    // ========================================
    // AXI4-Lite write path
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADCP_RESP_OKAY;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= {`ADCP_AXI_ADDR_W{1'b0}};
            wdata_reg <= 32'h0000_0000;
            extref_ctrl_reg <= 1'b0;
            int_mask_reg <= {`ADCP_INT_W{1'b0}};
            int_status_reg <= {`ADCP_INT_W{1'b0}};
            irq_o <= 1'b0;
        end else if (rst_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADCP_RESP_OKAY;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= {`ADCP_AXI_ADDR_W{1'b0}};
            wdata_reg <= 32'h0000_0000;
            extref_ctrl_reg <= 1'b0;
            int_mask_reg <= {`ADCP_INT_W{1'b0}};
            int_status_reg <= {`ADCP_INT_W{1'b0}};
            irq_o <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
            end
            if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `ADCP_RESP_OKAY;
                case (awaddr_reg)
                    `ADCP_REG_CTRL: begin
                        extref_ctrl_reg <= wdata_reg[`ADCP_CTRL_EXTREF];
                    end
                    `ADCP_REG_INT_MASK: begin
                        int_mask_reg <= wdata_reg[`ADCP_INT_W-1:0];
                    end
                    `ADCP_REG_INT_STATUS: begin
                    end
                    default: begin
                        s_axi_bresp <= `ADCP_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
            end
            // Set wins over clear
            int_status_reg <= (int_status_reg & ~int_clr) | int_set;
            irq_o <= |(((int_status_reg & ~int_clr) | int_set) & int_mask_reg);
        end
    end

    // ========================================
    // AXI4-Lite read path
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ADCP_RESP_OKAY;
        end else if (rst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ADCP_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `ADCP_RESP_OKAY;
                case (s_axi_araddr)
                    `ADCP_REG_CTRL: s_axi_rdata <= {31'h0000_0000, extref_ctrl_reg};
                    `ADCP_REG_DATA: s_axi_rdata <= {14'h0000, out_of_range_flag_o, sample_ready_n_o, word_reg};
                    `ADCP_REG_INT_STATUS: s_axi_rdata <= {30'h0000_0000, int_status_reg};
                    `ADCP_REG_INT_MASK: s_axi_rdata <= {30'h0000_0000, int_mask_reg};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `ADCP_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // adcp_port

// File: verif/adcp_port_properties.sv
// Checker for the converter output port
`timescale 1ns/10ps
`include "adcp_defs.vh"
module adcp_port_properties #(
    parameter DECIM = `ADCP_DECIM,
    parameter RAW_W = `ADCP_RAW_W
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire rst_n_i,
    input wire [RAW_W-1:0] filter_raw_i,
    input wire chip_select_n_i,
    input wire read_n_i,
    input wire external_ref_select_i,
    input wire [`ADCP_DATA_W-1:0] data_out_o,
    input wire data_oe_o,
    input wire sample_ready_n_o,
    input wire out_of_range_flag_o,
    input wire ref_positive_en_o,
    input wire ref_negative_en_o,
    input wire ref_mid_en_o,
    input wire irq_o
);
    // ========================================
    // Helper terms
    wire rst_any = rst_i || !rst_n_i;
    wire signed [RAW_W-1:0] raw_s = filter_raw_i;
    wire over = (raw_s > 32767) || (raw_s < -32768);
    wire idle = chip_select_n_i || read_n_i;
    wire refs_off = !ref_positive_en_o && !ref_negative_en_o && !ref_mid_en_o;
    wire cleared = (data_out_o == 16'h0) && sample_ready_n_o && !data_oe_o && refs_off;
    wire s = sample_ready_n_o;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_any);
    // ========================================
    // Properties
    property p_async_clear; disable iff (1'b0) !rst_n_i |-> cleared; endproperty
    a_async_clear: assert property (p_async_clear) else $error("async reset did not clear");
    property p_sync_clear; disable iff (1'b0) rst_i |=> cleared; endproperty
    a_sync_clear: assert property (p_sync_clear) else $error("reset did not clear");
    property p_first_fall; $fell(rst_i) && rst_n_i |-> s ##[2:3] $fell(s); endproperty
    a_first_fall: assert property (p_first_fall) else $error("first strobe late");
    property p_period; $fell(s) |-> !s [*4] ##1 s [*4] ##1 !s; endproperty
    a_period: assert property (p_period) else $error("strobe period wrong");
    property p_flag_hold; !$fell(s) |-> $stable(out_of_range_flag_o); endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag moved off the fall");
    property p_flag_clip; $fell(s) |-> out_of_range_flag_o == $past(over); endproperty
    a_flag_clip: assert property (p_flag_clip) else $error("flag wrong");
    property p_bus_zero; !data_oe_o |-> data_out_o == 16'h0; endproperty
    a_bus_zero: assert property (p_bus_zero) else $error("bus not zero");
    property p_bus_off; idle [*4] |=> !data_oe_o; endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus driven unselected");
    property p_bus_on; !idle [*4] |=> data_oe_o; endproperty
    a_bus_on: assert property (p_bus_on) else $error("bus not driven");
    property p_ext_ref; external_ref_select_i [*5] |=> refs_off; endproperty
    a_ext_ref: assert property (p_ext_ref) else $error("internal reference on");
    // Main scenarios reached
    c_flag: cover property ($rose(out_of_range_flag_o));
    c_read: cover property ($rose(data_oe_o));
    c_irq: cover property ($rose(irq_o));
endmodule // adcp_port_properties

bind adcp_port adcp_port_properties #(.DECIM(DECIM), .RAW_W(RAW_W)) adcp_port_properties_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .rst_n_i(rst_n_i), .filter_raw_i(filter_raw_i),
    .chip_select_n_i(chip_select_n_i), .read_n_i(read_n_i), .external_ref_select_i(external_ref_select_i),
    .data_out_o(data_out_o), .data_oe_o(data_oe_o), .sample_ready_n_o(sample_ready_n_o),
    .out_of_range_flag_o(out_of_range_flag_o), .ref_positive_en_o(ref_positive_en_o),
    .ref_negative_en_o(ref_negative_en_o), .ref_mid_en_o(ref_mid_en_o), .irq_o(irq_o)
);

// File: verif/adcp_host.sv
// Host model that reads the parallel bus once per sample period
`timescale 1ns/10ps
module adcp_host (
    input wire clk_i,
    input wire rdy_n_i,
    input wire oe_i,
    input wire [15:0] data_i,
    input wire [1:0] mode_i,
    output reg cs_n_o = 1'b1,
    output reg rd_n_o = 1'b1,
    output reg [15:0] word_o = 16'h0,
    output reg seen_o = 1'b0,
    output reg [7:0] cnt_o = 8'h0
);
    reg prev = 1'b1;
    reg [3:0] ph = 4'h0;
    // ========================================
    // Select window opens after the strobe falls and closes before the next fall
    always @(posedge clk_i) begin
        prev <= rdy_n_i;
        if (prev && !rdy_n_i) begin
            ph <= 4'h1;
        end else if (ph != 4'h0) begin
            ph <= ph + 4'h1;
        end
        if (ph == 4'h1) begin
            cs_n_o <= mode_i[1];
            rd_n_o <= mode_i[0];
        end
        if (ph == 4'h6) begin
            cs_n_o <= 1'b1;
            rd_n_o <= 1'b1;
            word_o <= data_i;
            seen_o <= oe_i;
            cnt_o <= cnt_o + 8'h1;
            ph <= 4'h0;
        end
    end
endmodule // adcp_host

// File: verif/adc_parallel_output_port_bench.sv
// Self-checking bench for the converter output port
`timescale 1ns/10ps
`include "adcp_defs.vh"
`define CHK(g, e) begin \
    samples_checked = samples_checked + 1; \
    if ((g) !== (e)) begin \
        error_cnt = error_cnt + 1; \
        $display("Error at %0t: got %h exp %h", $time, (g), (e)); \
    end \
end
module adc_parallel_output_port_bench;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg rst_n = 1'b1;
    reg ext = 1'b0;
    reg [17:0] raw = 18'h0;
    reg [1:0] mode = 2'b00;
    reg [3:0] awaddr = 4'h0, araddr = 4'h0;
    reg [31:0] wdata = 32'h0, rd;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, i0;
    reg [1:0] resp;
    wire awready, wready, bvalid, arready, rvalid, oe, rdy_n, flag, rp, rn, rm, irq, cs_n, rd_n, hseen;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] dout, hword;
    wire [7:0] hcnt;
    integer error_cnt = 0;
    integer samples_checked = 0;
    integer i;
    // Raw results with the expected word and flag of each
    localparam logic [6:0][17:0] TV = {18'h00001, 18'h3ffff, 18'h07fff, 18'h08000, 18'h1ffff, 18'h37fff, 18'h38000};
    localparam logic [6:0][15:0] TW = {16'h0001, 16'hffff, 16'h7fff, 16'h7fff, 16'h7fff, 16'h8000, 16'h8000};
    localparam logic [6:0] TF = 7'b0001110;
    adcp_port adcp_port_inst (
        .sys_clk_i(clk), .rst_i(rst), .rst_n_i(rst_n), .filter_raw_i(raw), .chip_select_n_i(cs_n),
        .read_n_i(rd_n), .external_ref_select_i(ext), .data_out_o(dout), .data_oe_o(oe),
        .sample_ready_n_o(rdy_n), .out_of_range_flag_o(flag), .ref_positive_en_o(rp),
        .ref_negative_en_o(rn), .ref_mid_en_o(rm), .irq_o(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    adcp_host adcp_host_inst (
        .clk_i(clk), .rdy_n_i(rdy_n), .oe_i(oe), .data_i(dout), .mode_i(mode),
        .cs_n_o(cs_n), .rd_n_o(rd_n), .word_o(hword), .seen_o(hseen), .cnt_o(hcnt)
    );
    // Free running sampling clock
    initial begin
        forever #50 clk = ~clk;
    end
    // One register access, write or read
    task automatic bus(input wr, input [3:0] a, input [31:0] d);
        integer n;
        reg done;
        begin
            done = 1'b0;
            @(posedge clk);
            awaddr <= a;
            araddr <= a;
            wdata <= d;
            awvalid <= wr;
            wvalid <= wr;
            bready <= wr;
            arvalid <= !wr;
            rready <= !wr;
            for (n = 0; n < 50 && !done; n = n + 1) begin
                @(posedge clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (arready) arvalid <= 1'b0;
                if (bvalid || rvalid) begin
                    resp = wr ? bresp : rresp;
                    rd = rdata;
                    bready <= 1'b0;
                    rready <= 1'b0;
                    done = 1'b1;
                end
            end
            `CHK(done, 1'b1)
        end
    endtask
    // Wait for the host's next read
    task automatic wait_rd;
        reg [7:0] c;
        integer n;
        begin
            @(posedge clk);
            c = hcnt;
            for (n = 0; n < 40 && hcnt === c; n = n + 1) @(posedge clk);
            `CHK(hcnt !== c, 1'b1)
        end
    endtask
    // Clipping and range flag over boundary codes
    task automatic t_clip;
        begin
            for (i = 0; i < 7; i = i + 1) begin
                raw <= TV[i];
                wait_rd;
                wait_rd;
                `CHK(hword, TW[i])
                `CHK(flag, TF[i])
            end
            bus(1'b0, `ADCP_REG_DATA, 32'h0);
            `CHK({rd[17], rd[15:0]}, 17'h00001)
        end
    endtask
    // Every select and read combination
    task automatic t_bus;
        integer m;
        begin
            for (m = 3; m >= 0; m = m - 1) begin
                mode <= m[1:0];
                wait_rd;
                wait_rd;
                `CHK(hseen, m == 0)
                `CHK(hword == 16'h0, m != 0)
            end
        end
    endtask
    // Asynchronous reset while the bus is driven
    task automatic t_reset;
        begin
            @(posedge clk);
            rst_n <= 1'b0;
            @(posedge clk);
            `CHK({dout, rdy_n, oe, flag, rp, rn, rm}, {16'h0, 1'b1, 1'b0, 1'b0, 3'b000})
            @(negedge clk);
            rst_n <= 1'b1;
            @(negedge clk);
            `CHK({rdy_n, oe}, 2'b10)
            @(negedge clk);
            `CHK(rdy_n, 1'b0)
            @(posedge clk);
        end
    endtask
    // Reference generators by pin and by control bit
    task automatic t_ref;
        begin
            ext <= 1'b1;
            repeat (5) @(posedge clk);
            `CHK({rp, rn, rm}, 3'b000)
            ext <= 1'b0;
            repeat (5) @(posedge clk);
            `CHK({rp, rn, rm}, 3'b111)
            bus(1'b1, `ADCP_REG_CTRL, 32'h1);
            repeat (5) @(posedge clk);
            `CHK({rp, rn, rm, resp}, 5'b00000)
            bus(1'b1, `ADCP_REG_CTRL, 32'h0);
        end
    endtask
    // Status, mask, interrupt and an unmapped address
    task automatic t_irq;
        begin
            bus(1'b1, `ADCP_REG_INT_MASK, 32'h0);
            bus(1'b1, `ADCP_REG_INT_STATUS, 32'h3);
            repeat (`ADCP_DECIM) @(posedge clk);
            bus(1'b0, `ADCP_REG_INT_STATUS, 32'h0);
            `CHK(rd[1:0], 2'b01)
            i0 = irq;
            bus(1'b1, `ADCP_REG_INT_MASK, 32'h3);
            repeat (2) @(posedge clk);
            `CHK(irq ^ i0, 1'b1)
            bus(1'b0, 4'h2, 32'h0);
            `CHK({resp, rd}, {`ADCP_RESP_SLVERR, 32'h0})
        end
    endtask
    // Verdict and end of run
    task test_done;
        begin
            if (error_cnt == 0 && samples_checked > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        `CHK({dout, rdy_n, oe, flag, rp, rn, rm}, {16'h0, 1'b1, 1'b0, 1'b0, 3'b000})
        rst <= 1'b0;
        repeat (47 * `ADCP_DECIM) @(posedge clk);
        t_clip;
        t_bus;
        t_reset;
        t_ref;
        t_irq;
        test_done;
    end
    // Watchdog
    initial begin
        #2000000;
        error_cnt = error_cnt + 1;
        test_done;
    end
endmodule // adc_parallel_output_port_bench
